// [dv/tcmc_channel_assertions.sv]
// port-level concurrent checks for the timer channel
`timescale 1ns/1ps
module tcmc_channel_assertions #(
    parameter CW = 16                  // counter width
) (
    input wire        clk_sys,         // master clock
    input wire        arst_n,          // async reset, active low
    input wire [7:0]  reg_addr,        // register address
    input wire [31:0] reg_wdata,       // write data
    input wire        reg_wr,          // write strobe
    input wire        reg_rd,          // read strobe
    input wire [31:0] reg_rdata,       // read data
    input wire        block_sync,      // block sync pulse
    input wire        io_line_a_out,   // line A drive
    input wire        io_line_a_oe,    // line A enable
    input wire        io_line_b_out,   // line B drive
    input wire        io_line_b_oe     // line B enable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    reg [31:0] mode_q; // shadow of the mode register, follows bus writes
    // shadow update, so checks need no view inside the design
    always @(posedge clk_sys or negedge arst_n)
        if (!arst_n) mode_q <= 32'h0000_0000;
        else if (reg_wr && reg_addr == 8'h04) mode_q <= reg_wdata;
    // soft command with line A set action in waveform view
    sequence soft_set_s;
        reg_wr && reg_addr == 8'h00 && reg_wdata[2] && mode_q[15] && mode_q[23:22] == 2'h1;
    endsequence
    // sync with line B clear action, line B an output
    sequence sync_clr_s;
        block_sync && mode_q[15] && mode_q[11:10] != 2'h0 && mode_q[31:30] == 2'h2;
    endsequence
    mode_readback_a: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == mode_q)
        else $error("mode readback differs");
    line_a_dir_a: assert property (io_line_a_oe == mode_q[15])
        else $error("line A direction wrong");
    line_b_dir_a: assert property (io_line_b_oe == (mode_q[15] && mode_q[11:10] != 2'h0))
        else $error("line B direction wrong");
    cmd_reads_zero_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 32'h0)
        else $error("command register readable");
    count_width_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata[31:16] == 16'h0)
        else $error("counter wider than 16 bits");
    status_mirror_a: assert property (reg_rd && reg_addr == 8'h20
        |=> reg_rdata[2:1] == $past({io_line_b_out, io_line_a_out}))
        else $error("status line mirror wrong");
    soft_line_a_a: assert property (soft_set_s |-> ##[1:2] io_line_a_out)
        else $error("soft trigger did not set line A");
    sync_line_b_a: assert property (sync_clr_s |-> ##[1:2] !io_line_b_out)
        else $error("sync did not clear line B");
endmodule // tcmc_channel_assertions

bind tcmc_channel tcmc_channel_assertions #(.CW(CW)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .block_sync(block_sync), .io_line_a_out(io_line_a_out),
    .io_line_a_oe(io_line_a_oe), .io_line_b_out(io_line_b_out), .io_line_b_oe(io_line_b_oe));

// [dv/tcmc_partner.sv]
// far-side model: external clock sources and the two channel pins
`timescale 1ns/1ps
module tcmc_partner (
    input  wire       clk_sys,   // stimulus follows this edge
    input  wire       a_oe,      // channel drives line A
    input  wire       a_out,     // channel level on line A
    input  wire       b_oe,      // channel drives line B
    input  wire       b_out,     // channel level on line B
    output wire       line_a,    // resolved line A
    output wire       line_b,    // resolved line B
    output reg  [2:0] ext_clk    // idle low, moves only on request
);
    reg [1:0] drv = 2'h0; // far-side drive of lines A and B
    initial ext_clk = 3'h0;
    // channel wins where it drives, else our level shows
    assign line_a = a_oe ? a_out : drv[0];
    assign line_b = b_oe ? b_out : drv[1];
    // n 0-2 picks a clock, 3-4 a line; changed just after an edge
    task put(input integer n, input logic v);
        @(posedge clk_sys);
        if (n < 3) ext_clk[n] <= v;
        else drv[n-3] <= v;
    endtask
endmodule // tcmc_partner

// [dv/testbench.sv]
// self-checking bench for the timer channel
`timescale 1ns/1ps
module testbench;
    reg         clk_sys = 1'b0;   // 40 MHz master clock
    reg         arst_n = 1'b0;    // reset held at start
    reg  [7:0]  reg_addr = 8'h0;  // bus address
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         block_sync = 1'b0;
    wire [31:0] reg_rdata;
    wire [2:0]  xc;
    wire        a_in, a_out, a_oe, b_in, b_out, b_oe;
    integer     fail_count = 0;
    integer     total_checks = 0;
    integer     i, n;
    reg  [31:0] d, e, va;         // read data and saved values
    always #12.5 clk_sys = ~clk_sys;
    tcmc_channel #(.CW(16)) u_tcmc_channel (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .block_sync(block_sync), .ext_clock_0(xc[0]),
        .ext_clock_1(xc[1]), .ext_clock_2(xc[2]), .io_line_a_in(a_in), .io_line_a_out(a_out),
        .io_line_a_oe(a_oe), .io_line_b_in(b_in), .io_line_b_out(b_out), .io_line_b_oe(b_oe));
    tcmc_partner u_tcmc_partner (.clk_sys(clk_sys), .a_oe(a_oe), .a_out(a_out), .b_oe(b_oe),
        .b_out(b_out), .line_a(a_in), .line_b(b_in), .ext_clk(xc));
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task cmp(input [31:0] got, input [31:0] exp, input string m);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // one-cycle write strobe, then released
    task wr(input [7:0] a, input [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clk_sys);
    endtask
    task sync_pulse;
        @(posedge clk_sys);
        block_sync <= 1'b1;
        @(posedge clk_sys);
        block_sync <= 1'b0;
    endtask
    // bounded wait for line A level, cycles waited in n
    task wait_a(input logic v);
        for (n = 0; n < 200 && a_out !== v; n = n + 1) @(posedge clk_sys);
        if (n == 200) begin
            cmp(0, 1, "line A wait ran out");
            final_report;
        end
    endtask
    task t_reset;
        rd(8'h04); cmp(d, 32'h0, "mode reset");
        rd(8'h10); cmp(d, 32'h0, "count reset");
        rd(8'h0C); cmp(d, 32'h0, "unmapped read");
    endtask
    task t_cmd;
        wr(8'h00, 32'h3); rd(8'h20); cmp(d[0], 0, "enable and disable");
        wr(8'h00, 32'h1); rd(8'h20); cmp(d[0], 1, "enable");
        rd(8'h00); cmp(d, 32'h0, "command write-only");
        wr(8'h00, 32'h0); rd(8'h20); cmp(d[0], 1, "zero command");
        wr(8'h00, 32'h2); rd(8'h10); e = d;
        cyc(8); rd(8'h10); cmp(d, e, "disabled count held");
    endtask
    task t_rate;
        // soft trigger restarts each of the first three divider ratios (/2, /8, /32) from zero
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h04, i); wr(8'h00, 32'h5); cyc(64); rd(8'h10);
            e = 64 >> (2 * i + 1);
            cmp(d + 1 >= e && d <= e + 2, 1, "divider rate");
        end
    endtask
    task t_ext;
        // one rising edge only counts when not inverted
        for (i = 0; i < 2; i = i + 1) begin
            wr(8'h04, 32'h5 | (i << 3)); wr(8'h00, 32'h5);
            u_tcmc_partner.put(0, 1'b1); cyc(6); rd(8'h10); cmp(d, 1 - i, "ext rise");
            u_tcmc_partner.put(0, 1'b0); cyc(6); rd(8'h10); cmp(d, 1, "ext fall");
        end
        wr(8'h04, 32'h10); wr(8'h00, 32'h5); cyc(20); rd(8'h10); cmp(d, 0, "gated");
        u_tcmc_partner.put(0, 1'b1); cyc(20); rd(8'h10); cmp(d >= 8, 1, "gate open");
        u_tcmc_partner.put(0, 1'b0);
    endtask
    task t_capture;
        // A loads on rise, B on fall, B load stops the clock
        wr(8'h04, 32'h0009_0040); wr(8'h00, 32'h5); cyc(10);
        u_tcmc_partner.put(3, 1'b1); cyc(10); u_tcmc_partner.put(3, 1'b0); cyc(6);
        rd(8'h14); va = d; rd(8'h18);
        cmp(va != 0 && d - va >= 4 && d - va <= 7, 1, "capture spacing");
        rd(8'h10); e = d; cyc(8); rd(8'h10); cmp(d, e, "stopped on load");
        wr(8'h14, 32'h1234); rd(8'h14); cmp(d, va, "value A read-only");
        // rising line A trigger restarts the stopped counter from zero
        wr(8'h04, 32'h0500); u_tcmc_partner.put(3, 1'b1); cyc(5);
        rd(8'h10); cmp(d <= 4, 1, "line A trigger");
    endtask
    task t_wave;
        wr(8'h1C, 32'hA); wr(8'h04, 32'h844C_C400); cyc(1);
        cmp({a_oe, b_oe}, 2'h3, "wave outputs");
        wr(8'h00, 32'h5); cyc(2);
        cmp({a_out, b_out}, 2'h2, "soft actions");
        wait_a(1'b0); wait_a(1'b1); cmp(n >= 19 && n <= 21, 1, "compare period");
        rd(8'h20); cmp(d[2], 1, "match C sets B");
        sync_pulse; cyc(2); cmp(b_out, 0, "sync on B");
        wr(8'h04, 32'h8040); wr(8'h00, 32'h5); cyc(40);
        rd(8'h10); cmp(d, 32'hA, "stop at C");
        sync_pulse; cyc(4); rd(8'h10); cmp(d <= 4, 1, "sync restart");
        wr(8'h04, 32'h8080); wr(8'h00, 32'h5); cyc(40);
        rd(8'h20); cmp(d[0], 0, "disable at C");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset;
        t_cmd;
        t_rate;
        t_ext;
        t_capture;
        t_wave;
        final_report;
    end
endmodule // testbench

// [rtl/tcmc_channel.v]
// one 16-bit timer/counter channel: command and mode registers, capture and waveform logic
`timescale 1ns/1ps
`include "tcmc_map.vh"

module tcmc_channel #(
    parameter CW = 16                          // counter width
) (
    input  wire          clk_sys,              // master clock, 40 MHz
    input  wire          arst_n,               // async reset, active low
    input  wire [7:0]    reg_addr,             // register byte address
    input  wire [31:0]   reg_wdata,            // write data
    input  wire          reg_wr,               // write strobe
    input  wire          reg_rd,               // read strobe
    output reg  [31:0]   reg_rdata,            // read data, cycle after strobe
    input  wire          block_sync,           // block-wide sync pulse
    input  wire          ext_clock_0,          // external clock 0
    input  wire          ext_clock_1,          // external clock 1
    input  wire          ext_clock_2,          // external clock 2
    input  wire          io_line_a_in,         // line A pin level
    output wire          io_line_a_out,        // line A drive level
    output wire          io_line_a_oe,         // line A output enable
    input  wire          io_line_b_in,         // line B pin level
    output wire          io_line_b_out,        // line B drive level
    output wire          io_line_b_oe          // line B output enable
);

    // synchronised input indices
    localparam IX_A  = 0;
    localparam IX_B  = 1;
    localparam IX_X0 = 2;

    reg  [31:0]   mode_q;                      // channel mode register
    reg  [CW-1:0] count_q;                     // counter
    reg  [CW-1:0] value_a_q;                   // capture/compare value A
    reg  [CW-1:0] value_b_q;                   // capture/compare value B
    reg  [CW-1:0] value_c_q;                   // compare value C
    reg           clk_en_q;                    // counter clock enabled
    reg           stop_q;                      // clock stopped until a trigger
    reg           line_a_q;                    // line A output level
    reg           line_b_q;                    // line B output level

    wire [4:0]    div_en;                      // prescaler enables
    wire [4:0]    s_lvl;                       // synchronised levels
    wire [4:0]    s_rise;                      // synchronised rising edges
    wire [4:0]    s_fall;                      // synchronised falling edges

    // mode fields
    wire [2:0] clock_select        = mode_q[`TCMC_CLKSEL_LSB+2:`TCMC_CLKSEL_LSB];
    wire       clock_invert        = mode_q[`TCMC_CLKINV_BIT];
    wire [1:0] burst_select        = mode_q[`TCMC_BURST_LSB+1:`TCMC_BURST_LSB];
    wire       stop_bit            = mode_q[`TCMC_STOP_BIT];
    wire       dis_bit             = mode_q[`TCMC_DIS_BIT];
    wire [1:0] edge_field          = mode_q[`TCMC_EDGE_LSB+1:`TCMC_EDGE_LSB];
    wire       compare_c_trigger   = mode_q[`TCMC_CTRIG_BIT];
    wire       wave                = mode_q[`TCMC_WAVE_BIT];
    wire       trigger_line_select = mode_q[`TCMC_TRGLINE_BIT];
    wire [1:0] load_a_edge         = mode_q[`TCMC_LDA_LSB+1:`TCMC_LDA_LSB];
    wire [1:0] load_b_edge         = mode_q[`TCMC_LDB_LSB+1:`TCMC_LDB_LSB];
    wire [1:0] event_source_select = mode_q[`TCMC_EVSRC_LSB+1:`TCMC_EVSRC_LSB];
    wire       event_trigger_enable = mode_q[`TCMC_EVTRG_BIT];
    wire [1:0] line_a_on_match_a   = mode_q[`TCMC_A_MATCHA_LSB+1:`TCMC_A_MATCHA_LSB];
    wire [1:0] line_a_on_match_c   = mode_q[`TCMC_A_MATCHC_LSB+1:`TCMC_A_MATCHC_LSB];
    wire [1:0] line_a_on_event     = mode_q[`TCMC_A_EVENT_LSB+1:`TCMC_A_EVENT_LSB];
    wire [1:0] line_a_on_soft_trig = mode_q[`TCMC_A_SOFT_LSB+1:`TCMC_A_SOFT_LSB];
    wire [1:0] line_b_on_match_b   = mode_q[`TCMC_B_MATCHB_LSB+1:`TCMC_B_MATCHB_LSB];
    wire [1:0] line_b_on_match_c   = mode_q[`TCMC_B_MATCHC_LSB+1:`TCMC_B_MATCHC_LSB];
    wire [1:0] line_b_on_event     = mode_q[`TCMC_B_EVENT_LSB+1:`TCMC_B_EVENT_LSB];
    wire [1:0] line_b_on_soft_trig = mode_q[`TCMC_B_SOFT_LSB+1:`TCMC_B_SOFT_LSB];

    // edge code: 0 none, 1 rising, 2 falling, 3 each edge
    function edge_hit;
        input [1:0] code;
        input       r;
        input       f;
        begin
            edge_hit = (code[0] & r) | (code[1] & f);
        end
    endfunction

    // action code applied to a line level
    function apply_act;
        input [1:0] code;
        input       lvl;
        begin
            case (code)
                `TCMC_ACT_SET:    apply_act = 1'b1;
                `TCMC_ACT_CLEAR:  apply_act = 1'b0;
                `TCMC_ACT_TOGGLE: apply_act = ~lvl;
                default:          apply_act = lvl;
            endcase
        end
    endfunction

    // register decode, used by the write paths; the read path decodes with a case
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // master clock dividers
    tcmc_prescaler #(
        .WIDTH   (`TCMC_DIV4_LOG2)
    ) u_prescaler (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .div_en  (div_en)
    );

    // pins cross into the master clock domain before any use
    tcmc_edge_sync #(
        .N       (5)
    ) u_edge_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin_in  ({ext_clock_2, ext_clock_1, ext_clock_0, io_line_b_in, io_line_a_in}),
        .level   (s_lvl),
        .rise    (s_rise),
        .fall    (s_fall)
    );

    // command decode
    wire cmd_wr     = reg_wr & hit(reg_addr, `TCMC_CMD_OFS);
    wire cmd_en     = cmd_wr & reg_wdata[`TCMC_CMD_CLOCK_ENABLE_CMD_BIT];
    wire cmd_dis    = cmd_wr & reg_wdata[`TCMC_CMD_CLOCK_DISABLE_CMD_BIT];
    wire soft_trig  = (cmd_wr & reg_wdata[`TCMC_CMD_SWTRIG_BIT]) | block_sync;

    // selected clock source, as a one-cycle tick
    reg src_tick;
    always @* begin
        case (clock_select)
            3'h0:    src_tick = div_en[0];
            3'h1:    src_tick = div_en[1];
            3'h2:    src_tick = div_en[2];
            3'h3:    src_tick = div_en[3];
            3'h4:    src_tick = div_en[4];
            3'h5:    src_tick = clock_invert ? s_fall[IX_X0]   : s_rise[IX_X0];
            3'h6:    src_tick = clock_invert ? s_fall[IX_X0+1] : s_rise[IX_X0+1];
            default: src_tick = clock_invert ? s_fall[IX_X0+2] : s_rise[IX_X0+2];
        endcase
    end

    // burst gating by an external clock level
    reg gate_ok;
    always @* begin
        case (burst_select)
            2'h0:    gate_ok = 1'b1;
            2'h1:    gate_ok = s_lvl[IX_X0];
            2'h2:    gate_ok = s_lvl[IX_X0+1];
            default: gate_ok = s_lvl[IX_X0+2];
        endcase
    end

    // divider ticks have no edge to invert; invert only matters for external sources
    wire          tick    = clk_en_q & ~stop_q & src_tick & gate_ok;
    wire [CW-1:0] cnt_inc = count_q + {{(CW-1){1'b0}}, 1'b1};

    // compares fire on the tick that brings the counter to the value
    wire match_a = wave & tick & (cnt_inc == value_a_q);
    wire match_b = wave & tick & (cnt_inc == value_b_q);
    wire match_c = tick & (cnt_inc == value_c_q);

    // capture mode external trigger
    wire trg_r   = trigger_line_select ? s_rise[IX_A] : s_rise[IX_B];
    wire trg_f   = trigger_line_select ? s_fall[IX_A] : s_fall[IX_B];
    wire cap_trg = ~wave & edge_hit(edge_field, trg_r, trg_f);

    // waveform mode external event source
    reg ev_r;
    reg ev_f;
    always @* begin
        case (event_source_select)
            2'h0: begin
                ev_r = s_rise[IX_B];
                ev_f = s_fall[IX_B];
            end
            2'h1: begin
                ev_r = s_rise[IX_X0];
                ev_f = s_fall[IX_X0];
            end
            2'h2: begin
                ev_r = s_rise[IX_X0+1];
                ev_f = s_fall[IX_X0+1];
            end
            default: begin
                ev_r = s_rise[IX_X0+2];
                ev_f = s_fall[IX_X0+2];
            end
        endcase
    end
    wire wave_ev = wave & edge_hit(edge_field, ev_r, ev_f);

    // anything that zeroes the counter and restarts it
    wire ext_trig = cap_trg | (wave_ev & event_trigger_enable);
    wire c_trig   = match_c & compare_c_trigger;
    wire any_trig = soft_trig | ext_trig | c_trig;

    // capture loads from line A edges
    wire load_a = ~wave & edge_hit(load_a_edge, s_rise[IX_A], s_fall[IX_A]);
    wire load_b = ~wave & edge_hit(load_b_edge, s_rise[IX_A], s_fall[IX_A]);

    // stop and disable sources differ by mode
    wire stop_ev = wave ? (match_c & stop_bit) : (load_b & stop_bit);
    wire dis_ev  = wave ? (match_c & dis_bit)  : (load_b & dis_bit);

    // line B only drives when it is not the event input
    wire line_b_drv = wave & (event_source_select != 2'h0);

    // counter register
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= {CW{1'b0}};
        end else if (any_trig) begin       // trigger zeroes the count
            count_q <= {CW{1'b0}};
        end else if (tick) begin           // normal count
            count_q <= cnt_inc;
        end
    end

    // clock enable and stop state; held until a command or event changes it
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clk_en_q <= 1'b0;
            stop_q   <= 1'b0;
        end else begin
            if (cmd_dis) begin             // disable wins over enable
                clk_en_q <= 1'b0;
            end else if (dis_ev) begin     // disable on load or compare
                clk_en_q <= 1'b0;
            end else if (cmd_en) begin     // enable
                clk_en_q <= 1'b1;
            end
            if (stop_ev) begin             // stop beats a same-cycle trigger
                stop_q <= 1'b1;
            end else if (any_trig) begin   // trigger restarts a stopped clock
                stop_q <= 1'b0;
            end
        end
    end

    // mode and value registers; capture loads and software writes
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q    <= `TCMC_MODE_RST;
            value_a_q <= `TCMC_VALUE_RST;
            value_b_q <= `TCMC_VALUE_RST;
            value_c_q <= `TCMC_VALUE_RST;
        end else begin
            if (reg_wr && hit(reg_addr, `TCMC_MODE_OFS)) begin
                mode_q <= reg_wdata;
            end
            if (load_a) begin              // capture has priority over nothing: read only here
                value_a_q <= count_q;
            end else if (wave && reg_wr && hit(reg_addr, `TCMC_VALUE_A_OFS)) begin
                value_a_q <= reg_wdata[CW-1:0];
            end
            if (load_b) begin
                value_b_q <= count_q;
            end else if (wave && reg_wr && hit(reg_addr, `TCMC_VALUE_B_OFS)) begin
                value_b_q <= reg_wdata[CW-1:0];
            end
            if (reg_wr && hit(reg_addr, `TCMC_VALUE_C_OFS)) begin
                value_c_q <= reg_wdata[CW-1:0];
            end
        end
    end

    // line A: highest priority event that has an action wins
    reg line_a_d;
    always @* begin
        line_a_d = line_a_q;
        if (!wave) begin                                   // capture: line is input
            line_a_d = line_a_q;
        end else if (soft_trig && line_a_on_soft_trig != `TCMC_ACT_NONE) begin
            line_a_d = apply_act(line_a_on_soft_trig, line_a_q);
        end else if (wave_ev && line_a_on_event != `TCMC_ACT_NONE) begin
            line_a_d = apply_act(line_a_on_event, line_a_q);
        end else if (match_c && line_a_on_match_c != `TCMC_ACT_NONE) begin
            line_a_d = apply_act(line_a_on_match_c, line_a_q);
        end else if (match_a) begin
            line_a_d = apply_act(line_a_on_match_a, line_a_q);
        end
    end

    // line B: same ordering, only while it is an output
    reg line_b_d;
    always @* begin
        line_b_d = line_b_q;
        if (!line_b_drv) begin                             // input use
            line_b_d = line_b_q;
        end else if (soft_trig && line_b_on_soft_trig != `TCMC_ACT_NONE) begin
            line_b_d = apply_act(line_b_on_soft_trig, line_b_q);
        end else if (wave_ev && line_b_on_event != `TCMC_ACT_NONE) begin
            line_b_d = apply_act(line_b_on_event, line_b_q);
        end else if (match_c && line_b_on_match_c != `TCMC_ACT_NONE) begin
            line_b_d = apply_act(line_b_on_match_c, line_b_q);
        end else if (match_b) begin
            line_b_d = apply_act(line_b_on_match_b, line_b_q);
        end
    end

    // output line flops
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            line_a_q <= 1'b0;
            line_b_q <= 1'b0;
        end else begin
            line_a_q <= line_a_d;
            line_b_q <= line_b_d;
        end
    end

    assign io_line_a_out = line_a_q;
    assign io_line_a_oe  = wave;
    assign io_line_b_out = line_b_q;
    assign io_line_b_oe  = line_b_drv;

    // read data, one cycle after the strobe; unmapped and write-only read zero
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TCMC_MODE_OFS:    reg_rdata <= mode_q;
                `TCMC_COUNT_OFS:   reg_rdata <= {{(32-CW){1'b0}}, count_q};
                `TCMC_VALUE_A_OFS: reg_rdata <= {{(32-CW){1'b0}}, value_a_q};
                `TCMC_VALUE_B_OFS: reg_rdata <= {{(32-CW){1'b0}}, value_b_q};
                `TCMC_VALUE_C_OFS: reg_rdata <= {{(32-CW){1'b0}}, value_c_q};
                `TCMC_STATUS_OFS:  reg_rdata <= {27'h000_0000, s_lvl[IX_B], s_lvl[IX_A],
                                                 line_b_q, line_a_q, clk_en_q & ~stop_q};
                default:           reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // tcmc_channel

// [rtl/tcmc_edge_sync.v]
// two-flop synchronisers with rise and fall detection for a group of external inputs
`timescale 1ns/1ps

module tcmc_edge_sync #(
    parameter N = 5                            // number of inputs
) (
    input  wire         clk_sys,               // master clock
    input  wire         arst_n,                // async reset, active low
    input  wire [N-1:0] pin_in,                // raw asynchronous inputs
    output wire [N-1:0] level,                 // synchronised level
    output wire [N-1:0] rise,                  // one-cycle rising edge pulse
    output wire [N-1:0] fall                   // one-cycle falling edge pulse
);

    reg [N-1:0] meta_q;                        // first stage, read by sync_q only
    reg [N-1:0] sync_q;                        // second stage
    reg [N-1:0] prev_q;                        // last synchronised level

    // double flop then one delay for edge compare
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= {N{1'b0}};
            sync_q <= {N{1'b0}};
            prev_q <= {N{1'b0}};
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule // tcmc_edge_sync

// [rtl/tcmc_map.vh]
// register offsets, field positions, reset values and divider ratios of the timer channel
`ifndef TCMC_MAP_VH
`define TCMC_MAP_VH

// register offsets (byte addresses)
`define TCMC_CMD_OFS        8'h00
`define TCMC_MODE_OFS       8'h04
`define TCMC_COUNT_OFS      8'h10
`define TCMC_VALUE_A_OFS    8'h14
`define TCMC_VALUE_B_OFS    8'h18
`define TCMC_VALUE_C_OFS    8'h1C
`define TCMC_STATUS_OFS     8'h20

// command register bits
`define TCMC_CMD_CLOCK_ENABLE_CMD_BIT  0
`define TCMC_CMD_CLOCK_DISABLE_CMD_BIT 1
`define TCMC_CMD_SWTRIG_BIT 2

// mode register fields, common to both views
`define TCMC_CLKSEL_LSB     0
`define TCMC_CLKINV_BIT     3
`define TCMC_BURST_LSB      4
`define TCMC_STOP_BIT       6
`define TCMC_DIS_BIT        7
`define TCMC_EDGE_LSB       8
`define TCMC_CTRIG_BIT      14
`define TCMC_WAVE_BIT       15
// capture view
`define TCMC_TRGLINE_BIT    10
`define TCMC_LDA_LSB        16
`define TCMC_LDB_LSB        18
// waveform view
`define TCMC_EVSRC_LSB      10
`define TCMC_EVTRG_BIT      12
`define TCMC_A_MATCHA_LSB   16
`define TCMC_A_MATCHC_LSB   18
`define TCMC_A_EVENT_LSB    20
`define TCMC_A_SOFT_LSB     22
`define TCMC_B_MATCHB_LSB   24
`define TCMC_B_MATCHC_LSB   26
`define TCMC_B_EVENT_LSB    28
`define TCMC_B_SOFT_LSB     30

// reset values
`define TCMC_MODE_RST       32'h0000_0000
`define TCMC_VALUE_RST      16'h0000

// prescaler: log2 of the master clock division ratios 2, 8, 32, 128, 1024
`define TCMC_DIV0_LOG2      1
`define TCMC_DIV1_LOG2      3
`define TCMC_DIV2_LOG2      5
`define TCMC_DIV3_LOG2      7
`define TCMC_DIV4_LOG2      10

// output actions
`define TCMC_ACT_NONE       2'h0
`define TCMC_ACT_SET        2'h1
`define TCMC_ACT_CLEAR      2'h2
`define TCMC_ACT_TOGGLE     2'h3

`endif

// [rtl/tcmc_prescaler.v]
// free-running master clock divider giving one-cycle enables at /2, /8, /32, /128 and /1024
`timescale 1ns/1ps
`include "tcmc_map.vh"

module tcmc_prescaler #(
    parameter WIDTH = `TCMC_DIV4_LOG2          // divider width, sets the slowest ratio
) (
    input  wire       clk_sys,                 // master clock
    input  wire       arst_n,                  // async reset, active low
    output wire [4:0] div_en                   // one-cycle enables, fastest first
);

    reg [WIDTH-1:0] div_q;                     // running divider count

    // count every master clock; never stopped so all ratios stay in phase
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= {WIDTH{1'b0}};
        end else begin
            div_q <= div_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // an enable fires when the low bits of the divider are all ones
    assign div_en[0] = &div_q[`TCMC_DIV0_LOG2-1:0];
    assign div_en[1] = &div_q[`TCMC_DIV1_LOG2-1:0];
    assign div_en[2] = &div_q[`TCMC_DIV2_LOG2-1:0];
    assign div_en[3] = &div_q[`TCMC_DIV3_LOG2-1:0];
    assign div_en[4] = &div_q[`TCMC_DIV4_LOG2-1:0];

endmodule // tcmc_prescaler
